// ---- rtl/amp_fault_status_bank.sv ----
// Function
// - left dc fault sets bit 3, hi-z
// - right dc fault sets bit 2, hi-z
// - left over-current sets bit 1, hi-z
// - right over-current sets bit 0, hi-z
// - listed errors also drive fault pin
// - flags hold until clear bit 7 written
// - otp crc failure sets global one bit 7
// - failed coefficient write sets bit 6
// - bit 5 shows boot load failure
// - clock error sets bit 2, hi-z, recovers
// - supply over-voltage sets bit 1, recovers
// - supply under-voltage sets bit 0, recovers
// - right current limit fault sets bit 2
// - left current limit fault sets bit 1
// - thermal shutdown sets bit 0, recovers
// - current limit warnings set bits 5, 4
// - thermal warning levels on bits 3..0
// - reserved channel bits read zero
// - write-only clear bit at own offset
// - dc mask suppresses dc pin reporting
// - oc mask suppresses oc pin reporting
`timescale 1ns/1ps
module amp_fault_status_bank (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // analog detector levels, asynchronous
    input wire fault_bank_pkg::fault_cond_type cond_in,
    // digital events, same clock
    input wire logic otp_crc_fail_in,
    input wire logic coef_write_fail_in,
    input wire logic boot_load_done_in,
    input wire logic boot_load_ok_in,
    // register port
    input wire fault_bank_pkg::reg_req_type reg_req_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // fault pin and power stage
    output logic fault_report_n_out,
    output logic stage_hiz_out
);

    // --------------------------------------------------------------
    // declarations
    // --------------------------------------------------------------
    fault_bank_pkg::bank_state_type state_reg;
    fault_bank_pkg::bank_state_type state_next;
    fault_bank_pkg::fault_cond_type live;
    logic report_active;
    logic hiz_request;

    // --------------------------------------------------------------
    // synchroniser and report logic
    // --------------------------------------------------------------
    fault_level_sync sync_inst (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .raw_in(cond_in),
        .sync_out(live)
    );

    fault_report_logic report_inst (
        .chan_err_in(state_reg.chan_err),
        .global_one_in(state_reg.global_one),
        .global_two_in(state_reg.global_two),
        .mask_ctrl_in(state_reg.mask_ctrl),
        .live_in(live),
        .report_active_out(report_active),
        .hiz_request_out(hiz_request)
    );

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb begin
        logic clear_hit;
        logic [7:0] chan_set;
        logic [7:0] one_set;
        logic [7:0] two_set;
        logic [7:0] warn_set;
        logic [7:0] boot_keep;
        clear_hit = 1'b0;
        chan_set = fault_bank_pkg::status_reset;
        one_set = fault_bank_pkg::status_reset;
        two_set = fault_bank_pkg::status_reset;
        warn_set = fault_bank_pkg::status_reset;
        boot_keep = fault_bank_pkg::status_reset;
        state_next = state_reg;

        // write of the clear bit; other bits of that word do nothing
        clear_hit = reg_req_in.wr
            && (reg_req_in.addr == fault_bank_pkg::clear_addr)
            && reg_req_in.wdata[fault_bank_pkg::clear_bit];

        // per-flag set terms; reserved positions never get a set
        chan_set[fault_bank_pkg::left_dc_bit] = live.left_dc;
        chan_set[fault_bank_pkg::right_dc_bit] = live.right_dc;
        chan_set[fault_bank_pkg::left_oc_bit] = live.left_oc;
        chan_set[fault_bank_pkg::right_oc_bit] = live.right_oc;

        one_set[fault_bank_pkg::otp_crc_bit] = otp_crc_fail_in;
        one_set[fault_bank_pkg::coef_write_bit] =
            coef_write_fail_in;
        one_set[fault_bank_pkg::clock_err_bit] =
            live.clock_error;
        one_set[fault_bank_pkg::supply_ov_bit] = live.supply_ov;
        one_set[fault_bank_pkg::supply_uv_bit] = live.supply_uv;

        two_set[fault_bank_pkg::right_cbc_bit] =
            live.right_cbc_fault;
        two_set[fault_bank_pkg::left_cbc_bit] =
            live.left_cbc_fault;
        two_set[fault_bank_pkg::thermal_sd_bit] =
            live.thermal_shutdown;

        warn_set[fault_bank_pkg::left_cbcw_bit] =
            live.left_cbc_warn;
        warn_set[fault_bank_pkg::right_cbcw_bit] =
            live.right_cbc_warn;
        warn_set[fault_bank_pkg::thermal_warn_msb:
            fault_bank_pkg::thermal_warn_lsb] =
            live.thermal_warning;

        // sticky: a set in the clearing cycle wins over the clear
        state_next.chan_err = (clear_hit ? fault_bank_pkg::status_reset
            : state_reg.chan_err) | chan_set;
        state_next.global_one = (clear_hit ? fault_bank_pkg::status_reset
            : state_reg.global_one) | one_set;
        state_next.global_two = (clear_hit ? fault_bank_pkg::status_reset
            : state_reg.global_two) | two_set;
        state_next.warning = (clear_hit ? fault_bank_pkg::status_reset
            : state_reg.warning) | warn_set;

        // boot load bit is a status, not sticky: last result wins
        boot_keep[fault_bank_pkg::boot_load_bit] =
            state_reg.global_one[fault_bank_pkg::boot_load_bit];
        if (boot_load_done_in) begin
            state_next.global_one[fault_bank_pkg::boot_load_bit] =
                ~boot_load_ok_in;
        end else begin
            state_next.global_one[fault_bank_pkg::boot_load_bit] =
                boot_keep[fault_bank_pkg::boot_load_bit];
        end

        // mask register write, reserved bit stays zero
        if (reg_req_in.wr
            && (reg_req_in.addr == fault_bank_pkg::mask_ctrl_addr)) begin
            state_next.mask_ctrl =
                reg_req_in.wdata & fault_bank_pkg::mask_writable;
        end

        // reads have no side effect on any flag
        state_next.rvalid = reg_req_in.rd;
        if (reg_req_in.rd) begin
            unique case (reg_req_in.addr)
                fault_bank_pkg::chan_err_addr: begin
                    state_next.rdata = state_reg.chan_err;
                end
                fault_bank_pkg::global_one_addr: begin
                    state_next.rdata = state_reg.global_one;
                end
                fault_bank_pkg::global_two_addr: begin
                    state_next.rdata = state_reg.global_two;
                end
                fault_bank_pkg::warning_addr: begin
                    state_next.rdata = state_reg.warning;
                end
                fault_bank_pkg::mask_ctrl_addr: begin
                    state_next.rdata = state_reg.mask_ctrl;
                end
                fault_bank_pkg::clear_addr: begin
                    state_next.rdata = fault_bank_pkg::clear_read;
                end
                default: begin
                    state_next.rdata = fault_bank_pkg::unmapped_read;
                end
            endcase
        end

        // pin lags its flag by one clock; stage hi-z likewise
        state_next.fault_report_n = ~report_active;
        state_next.stage_hiz = hiz_request;
    end

    // --------------------------------------------------------------
    // state register
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg.chan_err <= fault_bank_pkg::status_reset;
            state_reg.global_one <= fault_bank_pkg::status_reset;
            state_reg.global_two <= fault_bank_pkg::status_reset;
            state_reg.warning <= fault_bank_pkg::status_reset;
            state_reg.mask_ctrl <= fault_bank_pkg::mask_reset;
            state_reg.rdata <= fault_bank_pkg::unmapped_read;
            state_reg.rvalid <= 1'b0;
            state_reg.fault_report_n <= 1'b1;
            state_reg.stage_hiz <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    assign reg_rdata_out = state_reg.rdata;
    assign reg_rvalid_out = state_reg.rvalid;
    assign fault_report_n_out = state_reg.fault_report_n;
    assign stage_hiz_out = state_reg.stage_hiz;

endmodule // amp_fault_status_bank

// ---- rtl/fault_bank_pkg.sv ----
package fault_bank_pkg;

    // --------------------------------------------------------------
    // register offsets on the device register port
    // --------------------------------------------------------------
    localparam logic [7:0] chan_err_addr = 8'h70;
    localparam logic [7:0] global_one_addr = 8'h71;
    localparam logic [7:0] global_two_addr = 8'h72;
    localparam logic [7:0] warning_addr = 8'h73;
    localparam logic [7:0] mask_ctrl_addr = 8'h74;
    localparam logic [7:0] clear_addr = 8'h78;

    // --------------------------------------------------------------
    // reset and read values
    // --------------------------------------------------------------
    localparam logic [7:0] status_reset = 8'h00;
    localparam logic [7:0] mask_reset = 8'h00;
    localparam logic [7:0] unmapped_read = 8'h00;
    localparam logic [7:0] clear_read = 8'h00;
    // bit 3 of the mask register is reserved, read-only zero
    localparam logic [7:0] mask_writable = 8'hf7;

    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int unsigned left_dc_bit = 3;
    localparam int unsigned right_dc_bit = 2;
    localparam int unsigned left_oc_bit = 1;
    localparam int unsigned right_oc_bit = 0;

    localparam int unsigned otp_crc_bit = 7;
    localparam int unsigned coef_write_bit = 6;
    localparam int unsigned boot_load_bit = 5;
    localparam int unsigned clock_err_bit = 2;
    localparam int unsigned supply_ov_bit = 1;
    localparam int unsigned supply_uv_bit = 0;

    localparam int unsigned right_cbc_bit = 2;
    localparam int unsigned left_cbc_bit = 1;
    localparam int unsigned thermal_sd_bit = 0;

    localparam int unsigned left_cbcw_bit = 5;
    localparam int unsigned right_cbcw_bit = 4;
    localparam int unsigned thermal_warn_lsb = 0;
    localparam int unsigned thermal_warn_msb = 3;

    localparam int unsigned thermal_sd_mask_bit = 7;
    localparam int unsigned clock_mask_bit = 4;
    localparam int unsigned supply_mask_bit = 2;
    localparam int unsigned dc_mask_bit = 1;
    localparam int unsigned oc_mask_bit = 0;

    localparam int unsigned clear_bit = 7;

    // --------------------------------------------------------------
    // carriers
    // --------------------------------------------------------------
    // analog detector levels, asynchronous to clk_sys_in
    typedef struct packed {
        logic left_dc;
        logic right_dc;
        logic left_oc;
        logic right_oc;
        logic clock_error;
        logic supply_ov;
        logic supply_uv;
        logic thermal_shutdown;
        logic left_cbc_fault;
        logic right_cbc_fault;
        logic left_cbc_warn;
        logic right_cbc_warn;
        logic [3:0] thermal_warning;
    } fault_cond_type;

    typedef struct packed {
        fault_cond_type stage_one;
        fault_cond_type stage_two;
    } sync_state_type;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } reg_req_type;

    typedef struct packed {
        logic [7:0] chan_err;
        logic [7:0] global_one;
        logic [7:0] global_two;
        logic [7:0] warning;
        logic [7:0] mask_ctrl;
        logic [7:0] rdata;
        logic rvalid;
        logic fault_report_n;
        logic stage_hiz;
    } bank_state_type;

endpackage

// ---- rtl/fault_level_sync.sv ----
`timescale 1ns/1ps
module fault_level_sync (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // levels
    input wire fault_bank_pkg::fault_cond_type raw_in,
    output fault_bank_pkg::fault_cond_type sync_out
);

    fault_bank_pkg::sync_state_type state_reg;
    fault_bank_pkg::sync_state_type state_next;

    // --------------------------------------------------------------
    // two flops; only the second stage is ever read
    // --------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.stage_one = raw_in;
        state_next.stage_two = state_reg.stage_one;
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.stage_two;

endmodule // fault_level_sync

// ---- rtl/fault_report_logic.sv ----
`timescale 1ns/1ps
module fault_report_logic (
    // latched flags and mask
    input wire logic [7:0] chan_err_in,
    input wire logic [7:0] global_one_in,
    input wire logic [7:0] global_two_in,
    input wire logic [7:0] mask_ctrl_in,
    // live synchronised conditions
    input wire fault_bank_pkg::fault_cond_type live_in,
    // results
    output logic report_active_out,
    output logic hiz_request_out
);

    logic dc_any;
    logic oc_any;

    assign dc_any = chan_err_in[fault_bank_pkg::left_dc_bit]
        | chan_err_in[fault_bank_pkg::right_dc_bit];
    assign oc_any = chan_err_in[fault_bank_pkg::left_oc_bit]
        | chan_err_in[fault_bank_pkg::right_oc_bit];

    // --------------------------------------------------------------
    // fault pin: or of every unmasked reportable flag
    // --------------------------------------------------------------
    always_comb begin
        report_active_out =
            (dc_any & ~mask_ctrl_in[fault_bank_pkg::dc_mask_bit])
            | (oc_any
                & ~mask_ctrl_in[fault_bank_pkg::oc_mask_bit])
            | (global_one_in[fault_bank_pkg::clock_err_bit]
                & ~mask_ctrl_in[fault_bank_pkg::clock_mask_bit])
            | ((global_one_in[fault_bank_pkg::supply_ov_bit]
                | global_one_in[fault_bank_pkg::supply_uv_bit])
                & ~mask_ctrl_in[fault_bank_pkg::supply_mask_bit])
            | (global_two_in[fault_bank_pkg::thermal_sd_bit]
                & ~mask_ctrl_in[fault_bank_pkg::thermal_sd_mask_bit]);
    end

    // --------------------------------------------------------------
    // output stage hi-z
    // --------------------------------------------------------------
    // dc and over-current hold hi-z until cleared; clock, supply and
    // thermal follow the live condition so the stage recovers alone
    always_comb begin
        hiz_request_out = dc_any | oc_any
            | live_in.clock_error
            | live_in.supply_ov
            | live_in.supply_uv
            | live_in.thermal_shutdown;
    end

endmodule // fault_report_logic

// ---- testbench/bank_props.sv ----
`timescale 1ns/1ps
module bank_props (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // inputs
    input wire fault_bank_pkg::fault_cond_type cond_in,
    input wire logic otp_crc_fail_in,
    input wire logic coef_write_fail_in,
    input wire logic boot_load_done_in,
    input wire logic boot_load_ok_in,
    input wire fault_bank_pkg::reg_req_type reg_req_in,
    // outputs
    input wire logic [7:0] reg_rdata_out,
    input wire logic reg_rvalid_out,
    input wire logic fault_report_n_out,
    input wire logic stage_hiz_out
);
    // ----------------------------------------------------------
    // mask shadow, rebuilt from the writes seen on the port
    // ----------------------------------------------------------
    logic [7:0] mask_reg;
    logic mask_wr;
    logic rd71;
    assign mask_wr = reg_req_in.wr && (reg_req_in.addr == 8'h74);
    assign rd71 = reg_req_in.rd && (reg_req_in.addr == 8'h71);
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mask_reg <= 8'h00;
        end else if (mask_wr) begin
            mask_reg <= reg_req_in.wdata & 8'hf7;
        end
    end
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);
    a_read_answer: assert property (reg_req_in.rd
        |=> reg_rvalid_out)
        else $error("read not answered");
    a_unmapped_zero: assert property (reg_req_in.rd &&
        !(reg_req_in.addr inside {[8'h70:8'h74]}) |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    a_chan_upper: assert property (reg_req_in.rd &&
        reg_req_in.addr == 8'h70 |=> reg_rdata_out[7:4] == 4'h0)
        else $error("reserved channel bits set");
    a_mask_read: assert property (reg_req_in.rd &&
        reg_req_in.addr == 8'h74 |=> reg_rdata_out == $past(mask_reg))
        else $error("mask readback wrong");
    a_dc_pin: assert property (((cond_in.left_dc
        || cond_in.right_dc) && !mask_reg[1]) [*2]
        |-> ##[1:3] !fault_report_n_out)
        else $error("dc fault not on pin");
    a_chan_hiz: assert property ((cond_in.left_dc
        || cond_in.right_dc || cond_in.left_oc || cond_in.right_oc) [*2]
        |-> ##[1:3] stage_hiz_out)
        else $error("channel fault without hi-z");
    a_clock_pin: assert property ((cond_in.clock_error &&
        !mask_reg[4]) [*2] |-> ##[1:3] !fault_report_n_out)
        else $error("clock fault not on pin");
    a_thermal_shutdown_hiz: assert property (cond_in.thermal_shutdown [*2]
        |-> ##[1:3] stage_hiz_out)
        else $error("thermal shutdown without hi-z");
    a_sticky_pin: assert property (!fault_report_n_out &&
        !reg_req_in.wr && !$past(reg_req_in.wr) |=> !fault_report_n_out)
        else $error("fault pin released without clear");
    a_otp_flag: assert property (otp_crc_fail_in ##1 rd71
        |=> reg_rdata_out[7])
        else $error("crc flag missing");
    a_boot_flag: assert property (boot_load_done_in ##1 rd71
        |=> reg_rdata_out[5] == !$past(boot_load_ok_in, 2))
        else $error("boot flag wrong");
endmodule // bank_props

bind amp_fault_status_bank bank_props bank_props_inst (.clk_sys_in,
    .rst_n_in, .cond_in, .otp_crc_fail_in, .coef_write_fail_in,
    .boot_load_done_in, .boot_load_ok_in, .reg_req_in, .reg_rdata_out,
    .reg_rvalid_out, .fault_report_n_out, .stage_hiz_out);

// ---- testbench/host_model.sv ----
`timescale 1ns/1ps
module host_model (
    // clock
    input wire logic clk_sys_in,
    // register port
    output fault_bank_pkg::reg_req_type req_out,
    input wire logic [7:0] rdata_in,
    input wire logic rvalid_in
);
    // released lines show the inverse, so nothing leans on a stale bus
    initial req_out = '0;
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_in);
        req_out = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(negedge clk_sys_in);
        req_out = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        int n;
        @(negedge clk_sys_in);
        req_out = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(negedge clk_sys_in);
        req_out = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hff};
        n = 0;
        while (rvalid_in !== 1'b1 && n < 4) begin
            @(negedge clk_sys_in);
            n++;
        end
        d = (rvalid_in === 1'b1) ? rdata_in : 8'hxx;
    endtask
endmodule // host_model

// ---- testbench/tb_amp_fault_status_bank.sv ----
`timescale 1ns/1ps
module tb_amp_fault_status_bank;
    // ----------------------------------------------------------
    // signals and instances
    // ----------------------------------------------------------
    logic clk_sys_in;
    logic rst_n_in;
    fault_bank_pkg::fault_cond_type cond;
    logic otp_fail, coef_fail, boot_done, boot_ok;
    fault_bank_pkg::reg_req_type req;
    logic [7:0] rdata;
    logic rvalid, fault_n, hiz;
    int failures;
    int num_checks;
    amp_fault_status_bank amp_fault_status_bank_inst (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .cond_in(cond),
        .otp_crc_fail_in(otp_fail), .coef_write_fail_in(coef_fail),
        .boot_load_done_in(boot_done), .boot_load_ok_in(boot_ok),
        .reg_req_in(req), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .fault_report_n_out(fault_n), .stage_hiz_out(hiz));
    host_model host_model_inst (.clk_sys_in(clk_sys_in), .req_out(req),
        .rdata_in(rdata), .rvalid_in(rvalid));
    initial begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    // ----------------------------------------------------------
    // compares and helpers
    // ----------------------------------------------------------
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: read %h want %h", $time, got, exp);
        end
    endtask
    task automatic check1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: pin %b want %b", $time, got, exp);
        end
    endtask
    task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host_model_inst.read_reg(a, d);
        check8(d, e);
    endtask
    task automatic pins(input logic pin_n, input logic stage);
        check1(fault_n, pin_n);
        check1(hiz, stage);
    endtask
    task automatic hold_cond(input logic [15:0] c);
        @(negedge clk_sys_in);
        cond = fault_bank_pkg::fault_cond_type'(c);
        repeat (4) @(negedge clk_sys_in);
    endtask
    // called at a falling edge, lets the synchroniser drain
    task automatic drop_cond();
        cond = '0;
        repeat (4) @(negedge clk_sys_in);
    endtask
    task automatic clear_all();
        host_model_inst.write_reg(8'h78, 8'h80);
        repeat (2) @(negedge clk_sys_in);
    endtask
    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    task automatic t_reset();
        logic [7:0] a [7] = '{8'h70, 8'h71, 8'h72, 8'h73, 8'h74, 8'h78, 8'h7f};
        host_model_inst.write_reg(8'h70, 8'hff);
        foreach (a[i]) rd_exp(a[i], 8'h00);
        pins(1'b1, 1'b0);
        $display("reset test done");
    endtask
    task automatic t_channel();
        for (int i = 0; i < 4; i++) begin
            hold_cond(16'h8000 >> i);
            pins(1'b0, 1'b1);
            drop_cond();
            pins(1'b0, 1'b1);
            rd_exp(8'h70, 8'h08 >> i);
            rd_exp(8'h70, 8'h08 >> i);
            clear_all();
            rd_exp(8'h70, 8'h00);
            pins(1'b1, 1'b0);
        end
        $display("channel test done");
    endtask
    task automatic t_global();
        logic [15:0] src [4] = '{16'h0800, 16'h0400, 16'h0200, 16'h0100};
        logic [7:0] ra [4] = '{8'h71, 8'h71, 8'h71, 8'h72};
        logic [7:0] bits [4] = '{8'h04, 8'h02, 8'h01, 8'h01};
        for (int i = 0; i < 4; i++) begin
            hold_cond(src[i]);
            pins(1'b0, 1'b1);
            drop_cond();
            pins(1'b0, 1'b0);
            rd_exp(ra[i], bits[i]);
            clear_all();
            rd_exp(ra[i], 8'h00);
        end
        $display("global test done");
    endtask
    task automatic t_silent();
        for (int k = 0; k < 8; k++) begin
            hold_cond(16'h0001 << k);
            drop_cond();
            check1(fault_n, 1'b1);
            if (k > 5) begin
                rd_exp(8'h72, (k == 7) ? 8'h02 : 8'h04);
            end else begin
                rd_exp(8'h73, 8'h01 << k);
            end
            clear_all();
            rd_exp((k > 5) ? 8'h72 : 8'h73, 8'h00);
        end
        $display("warning test done");
    endtask
    task automatic t_events();
        @(negedge clk_sys_in);
        {otp_fail, coef_fail, boot_done, boot_ok} = 4'b1010;
        rd_exp(8'h71, 8'ha0);
        {otp_fail, coef_fail, boot_done} = 3'b010;
        rd_exp(8'h71, 8'he0);
        coef_fail = 1'b0;
        clear_all();
        rd_exp(8'h71, 8'h20);
        {boot_done, boot_ok} = 2'b11;
        rd_exp(8'h71, 8'h00);
        boot_done = 1'b0;
        $display("event test done");
    endtask
    task automatic t_masks();
        // one mask bit at a time, so a swapped mask bit shows on the pin
        logic [7:0] mbit [8] = '{8'h02, 8'h02, 8'h01, 8'h01, 8'h10, 8'h04,
            8'h04, 8'h80};
        host_model_inst.write_reg(8'h74, 8'hff);
        rd_exp(8'h74, 8'hf7);
        for (int i = 0; i < 8; i++) begin
            host_model_inst.write_reg(8'h74, mbit[i]);
            hold_cond(16'h8000 >> i);
            pins(1'b1, 1'b1);
            drop_cond();
            clear_all();
        end
        host_model_inst.write_reg(8'h74, 8'h00);
        rd_exp(8'h74, 8'h00);
        $display("mask test done");
    endtask
    // ----------------------------------------------------------
    // sequence, watchdog and verdict
    // ----------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        rst_n_in = 1'b0;
        cond = '0;
        {otp_fail, coef_fail, boot_done, boot_ok} = 4'b0000;
        failures = 0;
        num_checks = 0;
        repeat (3) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        t_reset();
        t_channel();
        t_global();
        t_silent();
        t_events();
        t_masks();
        wrap_up();
    end
    initial begin
        repeat (5000) @(posedge clk_sys_in);
        failures++;
        $display("Error at %0t: watchdog expired", $time);
        wrap_up();
    end
endmodule // tb_amp_fault_status_bank
